// ### hw/ilst_pkg.sv
// constants and types for the internal clock loop settling and trim block
package ilst_pkg;

    // clock and base clock timing
    localparam int          CLOCK_HZ      = 10_000_000;
    localparam int          BASE_HZ       = 307_200;
    localparam int          BASE_DIV_INT  = (CLOCK_HZ / BASE_HZ < 1) ? 1 : CLOCK_HZ / BASE_HZ;
    localparam logic [5:0]  BASE_DIV_LAST = 6'(BASE_DIV_INT - 1);
    localparam int          BASE_PER_CORR = 4;
    localparam logic [1:0]  CORR_LAST     = 2'(BASE_PER_CORR - 1);

    // oscillator control word {divider field, stage field}
    localparam logic [11:0] OSC_MAX       = 12'hFFF;
    localparam logic [11:0] STEP_COARSE   = 12'h020;
    localparam logic [11:0] STEP_MEDIUM   = 12'h008;
    localparam logic [11:0] STEP_FINE     = 12'h001;
    localparam logic [3:0]  DIV_SAT       = 4'h9;
    localparam logic [3:0]  DIV_RST       = 4'h5;   // arbitrary start point
    localparam logic [7:0]  STG_RST       = 8'h00;  // arbitrary start point
    localparam logic [4:0]  RING_MIN      = 5'h11;
    localparam int          STG_RING_LSB  = 5;

    // trim capacitor and multiplier
    localparam logic [9:0]  CAP_FIXED     = 10'h180;
    localparam logic [7:0]  TRIM_RST      = 8'h80;
    localparam logic [6:0]  MULT_RST      = 7'h15;

    // error band codes from the frequency comparator
    localparam logic [1:0]  BAND_OVER15   = 2'h0;
    localparam logic [1:0]  BAND_MID      = 2'h1;
    localparam logic [1:0]  BAND_UNDER5   = 2'h2;
    localparam logic [1:0]  BAND_LOCK     = 2'h3;

    typedef struct packed {
        logic       too_slow;
        logic [1:0] band;
    } ilst_err_t;

    typedef enum logic [1:0] {
        MODE_COARSE,
        MODE_MEDIUM,
        MODE_FINE
    } ilst_mode_t;

endpackage

// ### hw/ilst_sync.sv
// two-flop synchroniser for the comparator inputs
`timescale 1ns/1ps
module ilst_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// ### hw/ilst_loop.sv
// loop filter, trim capacitor and wait-mode wake for the internal clock generator
// Operation
// - restart settling on reset, writes, re-enable
// - one correction every four base periods
// - coarse steps above 15 percent error
// - medium steps between 15 and 5 percent
// - stable flag once error below 5 percent
// - single-unit steps below 5 percent, none when locked
// - capacitor is 384 fixed plus trim units
// - trim resets to 128, capacitor 512
// - larger trim gives lower base frequency
// - generator keeps running in wait mode
// - enabled generator interrupt wakes from wait
// - divider saturates at nine, divide by 512
// - divider moves only by stage carry, borrow
// - upper stage bits pick 17 to 31
`timescale 1ns/1ps
module ilst_loop (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic              i_icg_on,
    input  wire logic              i_wait_mode,
    input  wire logic              i_mult_wr,
    input  wire logic [6:0]        i_mult_data,
    input  wire logic              i_trim_wr,
    input  wire logic [7:0]        i_trim_data,
    input  wire ilst_pkg::ilst_err_t i_cmp_err,
    input  wire logic              i_irq_enable,
    input  wire logic              i_irq_pending,
    output logic [3:0]             o_osc_divider_field,
    output logic [7:0]             o_osc_stage_field,
    output logic [3:0]             o_div_shift,
    output logic [4:0]             o_ring_stages,
    output logic                   o_internal_clock_stable_flag,
    output logic [9:0]             o_trim_cap_units,
    output logic [6:0]             o_mult_factor,
    output logic [7:0]             o_trim_factor,
    output ilst_pkg::ilst_mode_t   o_loop_mode,
    output logic                   o_correction_pulse,
    output logic                   o_gen_active,
    output logic                   o_wake_request
);
    logic [2:0]           err_raw;
    ilst_pkg::ilst_err_t  err;
    logic [5:0]           base_cnt_r;
    logic [5:0]           base_cnt_nxt;
    logic [1:0]           quarter_r;
    logic [1:0]           quarter_nxt;
    logic [11:0]          osc_r;
    logic [11:0]          osc_nxt;
    logic [11:0]          step;
    logic                 stable_r;
    logic                 stable_nxt;
    ilst_pkg::ilst_mode_t mode_r;
    ilst_pkg::ilst_mode_t mode_nxt;
    logic [6:0]           mult_r;
    logic [6:0]           mult_nxt;
    logic [7:0]           trim_r;
    logic [7:0]           trim_nxt;
    logic                 on_prev_r;
    logic                 restart;
    logic [7:0]           gap_cnt_r;
    logic [7:0]           gap_cnt_nxt;
    logic                 corr_fire;
    logic [3:0]           div_shift_nxt;
    logic [4:0]           ring_nxt;
    logic [9:0]           cap_nxt;

    // comparator sits in the analog domain, so it is synchronised first
    ilst_sync #(
        .WIDTH (3)
    ) u_cmp_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_cmp_err),
        .o_sync  (err_raw)
    );
    assign err = ilst_pkg::ilst_err_t'(err_raw);

    function automatic logic [11:0] step_for(input logic [1:0] band);
        unique case (band)
            ilst_pkg::BAND_OVER15: step_for = ilst_pkg::STEP_COARSE;
            ilst_pkg::BAND_MID:    step_for = ilst_pkg::STEP_MEDIUM;
            ilst_pkg::BAND_UNDER5: step_for = ilst_pkg::STEP_FINE;
            default:               step_for = 12'h000;
        endcase
    endfunction

    function automatic ilst_pkg::ilst_mode_t mode_for(input logic [1:0] band);
        unique case (band)
            ilst_pkg::BAND_OVER15: mode_for = ilst_pkg::MODE_COARSE;
            ilst_pkg::BAND_MID:    mode_for = ilst_pkg::MODE_MEDIUM;
            default:               mode_for = ilst_pkg::MODE_FINE;
        endcase
    endfunction

    // software-side multiplier and trim values, reset to their defaults
    always_comb
    begin
        mult_nxt = i_mult_wr ? i_mult_data : mult_r;
        trim_nxt = i_trim_wr ? i_trim_data : trim_r;
        // a write of the same value still restarts: the filter cannot tell
        restart  = i_mult_wr | i_trim_wr | (i_icg_on & ~on_prev_r) | ~i_icg_on;
    end

    // base clock divider and correction window
    always_comb
    begin
        corr_fire = 1'b0;
        if (restart)
        begin
            base_cnt_nxt = 6'h00;
            quarter_nxt  = 2'h0;
        end
        else if (base_cnt_r == ilst_pkg::BASE_DIV_LAST)
        begin
            base_cnt_nxt = 6'h00;
            quarter_nxt  = quarter_r + 2'h1;
            corr_fire    = (quarter_r == ilst_pkg::CORR_LAST);
        end
        else
        begin
            base_cnt_nxt = base_cnt_r + 6'h01;
            quarter_nxt  = quarter_r;
        end
    end

    // loop filter: step size by error band, carry into divider field
    always_comb
    begin
        step       = step_for(err.band);
        osc_nxt    = osc_r;
        mode_nxt   = mode_r;
        stable_nxt = stable_r;
        if (restart)
        begin
            mode_nxt   = ilst_pkg::MODE_COARSE;
            stable_nxt = 1'b0;
        end
        else if (corr_fire)
        begin
            mode_nxt = mode_for(err.band);
            // one combined word: divider moves only on stage carry or borrow
            if (err.too_slow)
                osc_nxt = (osc_r < step) ? 12'h000 : osc_r - step;
            else
                osc_nxt = (osc_r > ilst_pkg::OSC_MAX - step) ? ilst_pkg::OSC_MAX : osc_r + step;
            if (err.band == ilst_pkg::BAND_UNDER5 || err.band == ilst_pkg::BAND_LOCK)
                stable_nxt = 1'b1;
        end
    end

    // oscillator decode, capacitor size
    always_comb
    begin
        div_shift_nxt = (osc_nxt[11:8] > ilst_pkg::DIV_SAT) ? ilst_pkg::DIV_SAT : osc_nxt[11:8];
        ring_nxt      = ilst_pkg::RING_MIN + {1'b0, osc_nxt[7:ilst_pkg::STG_RING_LSB], 1'b0};
        // more units, more capacitance, lower base frequency
        cap_nxt       = ilst_pkg::CAP_FIXED + {2'b00, trim_nxt};
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            base_cnt_r                   <= 6'h00;
            quarter_r                    <= 2'h0;
            osc_r                        <= {ilst_pkg::DIV_RST, ilst_pkg::STG_RST};
            mode_r                       <= ilst_pkg::MODE_COARSE;
            stable_r                     <= 1'b0;
            mult_r                       <= ilst_pkg::MULT_RST;
            trim_r                       <= ilst_pkg::TRIM_RST;
            on_prev_r                    <= 1'b0;
            o_div_shift                  <= ilst_pkg::DIV_RST;
            o_ring_stages                <= ilst_pkg::RING_MIN;
            o_trim_cap_units             <= ilst_pkg::CAP_FIXED + {2'b00, ilst_pkg::TRIM_RST};
            o_correction_pulse           <= 1'b0;
            o_gen_active                 <= 1'b0;
            o_wake_request               <= 1'b0;
        end
        else
        begin
            base_cnt_r                   <= base_cnt_nxt;
            quarter_r                    <= quarter_nxt;
            osc_r                        <= osc_nxt;
            mode_r                       <= mode_nxt;
            stable_r                     <= stable_nxt;
            mult_r                       <= mult_nxt;
            trim_r                       <= trim_nxt;
            on_prev_r                    <= i_icg_on;
            o_div_shift                  <= div_shift_nxt;
            o_ring_stages                <= ring_nxt;
            o_trim_cap_units             <= cap_nxt;
            o_correction_pulse           <= corr_fire;
            // wait mode does not gate the generator
            o_gen_active                 <= i_icg_on;
            o_wake_request               <= i_wait_mode & i_irq_enable & i_irq_pending;
        end
    end

    assign o_osc_divider_field          = osc_r[11:8];
    assign o_osc_stage_field            = osc_r[7:0];
    assign o_internal_clock_stable_flag = stable_r;
    assign o_mult_factor                = mult_r;
    assign o_trim_factor                = trim_r;
    assign o_loop_mode                  = mode_r;

    // independent count since the last restart or correction, for the period check
    always_comb
    begin
        gap_cnt_nxt = (restart || corr_fire) ? 8'h00 : gap_cnt_r + 8'h01;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            gap_cnt_r <= 8'h00;
        else
            gap_cnt_r <= gap_cnt_nxt;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_fire_band(logic [1:0] b, logic slow);
        corr_fire && err.band == b && err.too_slow == slow;
    endsequence

    chk_restart_clears: assert property (restart |=> !o_internal_clock_stable_flag)
        else $error("stable flag survived a restart");
    chk_write_restarts: assert property ((i_mult_wr || i_trim_wr) |=> o_loop_mode == ilst_pkg::MODE_COARSE)
        else $error("write did not restart settling");
    chk_corr_spacing: assert property (corr_fire |=> !corr_fire [*8])
        else $error("corrections too close together");
    chk_corr_period: assert property (corr_fire |-> gap_cnt_r == 8'(ilst_pkg::BASE_PER_CORR * ilst_pkg::BASE_DIV_INT - 1))
        else $error("correction period is not four base periods");
    chk_coarse_step: assert property (s_fire_band(ilst_pkg::BAND_OVER15, 1'b1)
        ##0 (osc_r >= ilst_pkg::STEP_COARSE) |=> osc_r == $past(osc_r) - ilst_pkg::STEP_COARSE)
        else $error("coarse step size wrong");
    chk_medium_step: assert property (s_fire_band(ilst_pkg::BAND_MID, 1'b0)
        ##0 (osc_r <= ilst_pkg::OSC_MAX - ilst_pkg::STEP_MEDIUM) |=> osc_r == $past(osc_r) + ilst_pkg::STEP_MEDIUM)
        else $error("medium step size wrong");
    chk_fine_step: assert property (s_fire_band(ilst_pkg::BAND_UNDER5, 1'b0) ##0 (osc_r != ilst_pkg::OSC_MAX)
        |=> osc_r == $past(osc_r) + ilst_pkg::STEP_FINE)
        else $error("fine step size wrong");
    chk_stable_set: assert property (corr_fire && err.band == ilst_pkg::BAND_UNDER5
        |=> o_internal_clock_stable_flag ##1 o_loop_mode == ilst_pkg::MODE_FINE || restart)
        else $error("stable flag not set below five percent");
    chk_osc_quiet: assert property (!corr_fire |=> $stable(osc_r))
        else $error("oscillator word moved without a correction");
    chk_cap_units: assert property (i_trim_wr |=> o_trim_cap_units == 10'(ilst_pkg::CAP_FIXED + $past(i_trim_data)))
        else $error("capacitor size does not follow trim");
    chk_div_sat: assert property (o_div_shift == ((o_osc_divider_field > ilst_pkg::DIV_SAT)
        ? ilst_pkg::DIV_SAT : o_osc_divider_field))
        else $error("divider saturation wrong");
    chk_ring_len: assert property (o_ring_stages == 5'(ilst_pkg::RING_MIN + 2 * o_osc_stage_field[7:5]))
        else $error("ring length decode wrong");
    chk_wait_wake: assert property (i_wait_mode && i_irq_enable && i_irq_pending && i_icg_on
        |=> o_wake_request && o_gen_active)
        else $error("generator stopped or no wake in wait mode");
endmodule

// ### bench/tb_ilst_loop.sv
// self-checking bench for the internal clock loop settling and trim block
`timescale 1ns/1ps
module tb_ilst_loop;
    logic                 i_clock       = 1'b0;
    logic                 i_rst         = 1'b1;
    logic                 i_icg_on      = 1'b0;
    logic                 i_wait_mode   = 1'b0;
    logic                 i_mult_wr     = 1'b0;
    logic [6:0]           i_mult_data   = 7'h00;
    logic                 i_trim_wr     = 1'b0;
    logic [7:0]           i_trim_data   = 8'h00;
    ilst_pkg::ilst_err_t  i_cmp_err     = '0;
    logic                 i_irq_enable  = 1'b0;
    logic                 i_irq_pending = 1'b0;
    logic [3:0]           o_osc_divider_field;
    logic [7:0]           o_osc_stage_field;
    logic [3:0]           o_div_shift;
    logic [4:0]           o_ring_stages;
    logic                 o_internal_clock_stable_flag;
    logic [9:0]           o_trim_cap_units;
    logic [6:0]           o_mult_factor;
    logic [7:0]           o_trim_factor;
    ilst_pkg::ilst_mode_t o_loop_mode;
    logic                 o_correction_pulse;
    logic                 o_gen_active;
    logic                 o_wake_request;
    int                   err_total = 0;
    int                   tests_run = 0;
    logic [11:0]          exp_word  = 12'h500;
    logic                 exp_stab  = 1'b0;
    int                   n;
    int                   cyc       = 0;
    int                   last_cyc  = 0;

    always #50 i_clock = ~i_clock;

    // edge count, read a little after the pulse edge by the correction gap check
    always @(posedge i_clock) cyc++;

    ilst_loop uut (
        .i_clock(i_clock), .i_rst(i_rst), .i_icg_on(i_icg_on), .i_wait_mode(i_wait_mode),
        .i_mult_wr(i_mult_wr), .i_mult_data(i_mult_data), .i_trim_wr(i_trim_wr),
        .i_trim_data(i_trim_data), .i_cmp_err(i_cmp_err), .i_irq_enable(i_irq_enable),
        .i_irq_pending(i_irq_pending), .o_osc_divider_field(o_osc_divider_field),
        .o_osc_stage_field(o_osc_stage_field), .o_div_shift(o_div_shift),
        .o_ring_stages(o_ring_stages), .o_internal_clock_stable_flag(o_internal_clock_stable_flag),
        .o_trim_cap_units(o_trim_cap_units), .o_mult_factor(o_mult_factor),
        .o_trim_factor(o_trim_factor), .o_loop_mode(o_loop_mode),
        .o_correction_pulse(o_correction_pulse), .o_gen_active(o_gen_active),
        .o_wake_request(o_wake_request)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // bounded wait for the next correction pulse, counting clock edges
    task automatic wait_pulse(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge i_clock);
            #1;
            cnt++;
        end
        while (o_correction_pulse !== 1'b1 && cnt < 400);
    endtask

    // one correction with the given error band; word follows the bench's own model
    task automatic corr(input logic [1:0] band, input logic slow, input logic [11:0] step,
                        input ilst_pkg::ilst_mode_t mode, input logic gap);
        int cnt;
        @(negedge i_clock);
        i_cmp_err = '{too_slow: slow, band: band};
        wait_pulse(cnt);
        check("pulse", o_correction_pulse, 1'b1);
        if (gap)
            check("gap", cyc - last_cyc, 128);
        last_cyc = cyc;
        if (band != ilst_pkg::BAND_LOCK)
        begin
            if (slow)
                exp_word = (exp_word < step) ? 12'h000 : exp_word - step;
            else
                exp_word = ({1'b0, exp_word} + step > 13'hFFF) ? 12'hFFF : exp_word + step;
            check("mode", o_loop_mode, mode);
        end
        exp_stab = exp_stab | (band >= ilst_pkg::BAND_UNDER5);
        check("word", {o_osc_divider_field, o_osc_stage_field}, exp_word);
        check("shift", o_div_shift, (exp_word[11:8] > 4'h9) ? 4'h9 : exp_word[11:8]);
        check("ring", o_ring_stages, 17 + 2 * exp_word[7:5]);
        check("stable", o_internal_clock_stable_flag, exp_stab);
    endtask

    // write pulse on trim or multiplier, then the restart effects
    task automatic write_reg(input logic is_trim, input logic [7:0] val);
        @(negedge i_clock);
        i_trim_wr = is_trim;
        i_mult_wr = ~is_trim;
        i_trim_data = val;
        i_mult_data = val[6:0];
        @(negedge i_clock);
        i_trim_wr = 1'b0;
        i_mult_wr = 1'b0;
        exp_stab = 1'b0;
        check("restart_stable", o_internal_clock_stable_flag, 1'b0);
        check("restart_mode", o_loop_mode, ilst_pkg::MODE_COARSE);
        if (is_trim)
        begin
            check("trim", o_trim_factor, val);
            check("cap", o_trim_cap_units, 10'h180 + val);
        end
        else
            check("mult", o_mult_factor, val[6:0]);
    endtask

    initial
    begin
        repeat (2) @(negedge i_clock);
        check("rst_word", {o_osc_divider_field, o_osc_stage_field}, 12'h500);
        check("rst_trim", o_trim_factor, 8'h80);
        check("rst_cap", o_trim_cap_units, 10'h200);
        check("rst_mult", o_mult_factor, 7'h15);
        check("rst_stable", o_internal_clock_stable_flag, 1'b0);
        i_rst = 1'b0;
        i_icg_on = 1'b1;
        corr(2'h0, 1'b0, ilst_pkg::STEP_COARSE, ilst_pkg::MODE_COARSE, 1'b0);
        repeat (2) corr(2'h0, 1'b0, ilst_pkg::STEP_COARSE, ilst_pkg::MODE_COARSE, 1'b1);
        corr(2'h1, 1'b1, ilst_pkg::STEP_MEDIUM, ilst_pkg::MODE_MEDIUM, 1'b1);
        corr(2'h1, 1'b0, ilst_pkg::STEP_MEDIUM, ilst_pkg::MODE_MEDIUM, 1'b1);
        corr(2'h2, 1'b0, ilst_pkg::STEP_FINE, ilst_pkg::MODE_FINE, 1'b1);
        corr(2'h3, 1'b0, 12'h000, ilst_pkg::MODE_FINE, 1'b1);
        // wake needs all three terms, so each is dropped once
        @(negedge i_clock);
        i_wait_mode = 1'b1;
        i_irq_enable = 1'b1;
        i_irq_pending = 1'b1;
        @(negedge i_clock);
        check("wake", o_wake_request, 1'b1);
        corr(2'h2, 1'b1, ilst_pkg::STEP_FINE, ilst_pkg::MODE_FINE, 1'b1);
        check("active", o_gen_active, 1'b1);
        @(negedge i_clock);
        i_irq_enable = 1'b0;
        @(negedge i_clock);
        check("wake_off", o_wake_request, 1'b0);
        i_irq_enable = 1'b1;
        i_irq_pending = 1'b0;
        @(negedge i_clock);
        check("wake_nopend", o_wake_request, 1'b0);
        i_irq_pending = 1'b1;
        i_wait_mode = 1'b0;
        @(negedge i_clock);
        check("wake_nowait", o_wake_request, 1'b0);
        write_reg(1'b1, 8'hFF);
        write_reg(1'b1, 8'h00);
        write_reg(1'b1, 8'h80);
        // base clock measured 3.90 percent fast: add 3.90 / 0.195 units
        write_reg(1'b1, 8'(128 + 3900 / 195));
        write_reg(1'b0, 8'h54);
        corr(2'h2, 1'b0, ilst_pkg::STEP_FINE, ilst_pkg::MODE_FINE, 1'b0);
        @(negedge i_clock);
        i_icg_on = 1'b0;
        @(negedge i_clock);
        check("off_stable", o_internal_clock_stable_flag, 1'b0);
        check("off_active", o_gen_active, 1'b0);
        exp_stab = 1'b0;
        wait_pulse(n);
        check("off_idle", n, 400);
        @(negedge i_clock);
        i_icg_on = 1'b1;
        corr(2'h0, 1'b0, ilst_pkg::STEP_COARSE, ilst_pkg::MODE_COARSE, 1'b0);
        repeat (90) corr(2'h0, 1'b0, ilst_pkg::STEP_COARSE, ilst_pkg::MODE_COARSE, 1'b1);
        repeat (130) corr(2'h0, 1'b1, ilst_pkg::STEP_COARSE, ilst_pkg::MODE_COARSE, 1'b1);
        @(negedge i_clock);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clock);
        check("rerst_word", {o_osc_divider_field, o_osc_stage_field}, 12'h500);
        check("rerst_mult", o_mult_factor, 7'h15);
        check("rerst_trim", o_trim_factor, 8'h80);
        check("rerst_stable", o_internal_clock_stable_flag, 1'b0);
        check("rerst_active", o_gen_active, 1'b0);
        give_verdict();
    end

    // run needs about 30k cycles; cut off well beyond that
    initial
    begin
        #6_000_000;
        check("watchdog", 1'b0, 1'b1);
        give_verdict();
    end
endmodule
